/* File: expander_regs.svh */
// Register offsets, field positions and reset values of the I/O expander
`ifndef EXPANDER_REGS_SVH
`define EXPANDER_REGS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define ADDR_IO_DIRECTION        4'h0
`define ADDR_INPUT_POLARITY      4'h1
`define ADDR_CHANGE_INT_ENABLE   4'h2
`define ADDR_DEFAULT_COMPARE     4'h3
`define ADDR_INT_COND_SELECT     4'h4
`define ADDR_DEVICE_CONFIG       4'h5
`define ADDR_PULLUP_ENABLE       4'h6
`define ADDR_INTERRUPT_FLAGS     4'h7
`define ADDR_INTERRUPT_CAPTURE   4'h8
`define ADDR_PORT_VALUE          4'h9
`define ADDR_OUTPUT_LATCH        4'ha
`define ADDR_LAST                4'ha

// ************************************************************
// Reset values
// ************************************************************
`define RST_IO_DIRECTION         8'hff
`define RST_ZERO                 8'h00

// ************************************************************
// Device configuration fields
// ************************************************************
`define CFG_SEQ_DISABLE_BIT      5
`define CFG_OPEN_DRAIN_BIT       2
`define CFG_INT_POL_BIT          1
`define CFG_WRITE_MASK           8'h3e

// ************************************************************
// Control byte layout
// ************************************************************
`define CTRL_FIXED               4'h4
`define CTRL_RW_BIT              0

`endif

/* File: expander_pkg.sv */
// Types shared by the I/O expander design files
package expander_pkg;

	// Position inside one chip-select frame
	typedef enum logic [3:0]
	{
		frame_opcode = 4'b0001,
		frame_addr   = 4'b0010,
		frame_data   = 4'b0100,
		frame_skip   = 4'b1000
	} frame_state_t;

endpackage : expander_pkg

/* File: pin_sync.sv */
// Two-flop synchroniser bank for asynchronous pins
`timescale 1ns/10ps

module pin_sync
#(
	parameter int WIDTH = 8
)
(
	// Clock
	input  wire logic             sys_clk,
	// Asynchronous pins
	input  wire logic [WIDTH-1:0] async_in,
	// Synchronised levels
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// ************************************************************
	// One synchroniser per bit
	// ************************************************************
	generate
		for (genvar i = 0; i < WIDTH; i++)
		begin : g_bit
			// First stage is read only by the second
			always_ff @(posedge sys_clk)
			begin
				meta_q[i]   <= async_in[i];
				sync_out[i] <= meta_q[i];
			end
		end
	endgenerate

endmodule : pin_sync

/* File: spi_link.sv */
// Mode 0 serial shifter working on synchronised link pins
`timescale 1ns/10ps

module spi_link
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Synchronised link pins
	input  wire logic       sck_s,
	input  wire logic       cs_n_s,
	input  wire logic       si_s,
	// Core side
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_enable,
	output logic            frame_start,
	output logic            rx_valid,
	output logic      [7:0] rx_byte,
	// Serial output pin
	output logic            so_out,
	output logic            so_oe
);

	logic       sck_prev_q;
	logic       cs_prev_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_in_q;
	logic [7:0] shift_out_q;
	logic       sck_rise;
	logic       sck_fall;

	// ************************************************************
	// Edge detection on the sampled link clock
	// ************************************************************
	assign sck_rise    = sck_s & ~sck_prev_q & ~cs_n_s;
	assign sck_fall    = ~sck_s & sck_prev_q & ~cs_n_s;
	assign frame_start = cs_prev_q & ~cs_n_s;
	// Combinational to leave the core time to prepare the next byte
	assign rx_valid    = sck_rise & (bit_cnt_q == 3'h7);
	assign rx_byte     = {shift_in_q[6:0], si_s};

	// Previous levels
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b1;
		end
		else
		begin
			sck_prev_q <= sck_s;
			cs_prev_q  <= cs_n_s;
		end
	end

	// ************************************************************
	// Receive on rising edges, MSB first
	// ************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst || cs_n_s)
		begin
			bit_cnt_q  <= 3'h0;
			shift_in_q <= 8'h00;
		end
		else if (sck_rise)
		begin
			bit_cnt_q  <= bit_cnt_q + 3'h1;
			shift_in_q <= {shift_in_q[6:0], si_s};
		end
	end

	// ************************************************************
	// Transmit on falling edges; a new byte loads at bit zero
	// ************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			shift_out_q <= 8'h00;
			so_out      <= 1'b0;
		end
		else if (sck_fall)
		begin
			if (bit_cnt_q == 3'h0)
			begin
				so_out      <= tx_byte[7];
				shift_out_q <= {tx_byte[6:0], 1'b0};
			end
			else
			begin
				so_out      <= shift_out_q[7];
				shift_out_q <= {shift_out_q[6:0], 1'b0};
			end
		end
	end

	// Output released whenever the frame is not a read
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			so_oe <= 1'b0;
		else
			so_oe <= ~cs_n_s & tx_enable;
	end

endmodule : spi_link

/* File: serial_io_expander_core.sv */
// Eight-bit I/O expander core with serial register access
//
// Contract
// - Eight bidirectional port pins, all inputs after reset.
// - Interrupt pin selectable active-high, active-low push-pull, or open-drain.
// - Change mode flags an enabled input that differs from its last sampled pin level.
// - Compare mode flags an enabled input that differs from its default-compare bit.
// - Each input uses exactly one of the two interrupt conditions.
// - Port values are captured into the capture register when an interrupt occurs.
// - Power-on reset loads register defaults and restarts the frame state machine.
// - Three hardware address bits allow eight devices on one bus.
// - Two hardware address bits allow four devices on one chip select.
// - Polarity bits invert the matching port register input bits.
// - Each pin individually enabled for interrupt-on-change and/or weak pull-up.
// - Eleven byte registers at 00h to 0Ah; capture register at 08h is read-only.
// - With sequential-disable clear, the pointer advances after each byte.
// - With sequential-disable set, the pointer stays on the same register.
// - Auto-increment is the behaviour after reset.
// - Every register returns its contents when read.
// - External reset input resets the device independently of power-on reset.
// - Direction bit 1 makes an input with driver off; 0 makes an output.
// - Sequential pointer wraps to zero after the last register.
// - Port read gives pins, port write goes to latch, latch read gives latch.
`timescale 1ns/10ps
`include "expander_regs.svh"

module serial_io_expander_core
#(
	parameter int HW_ADDR_BITS = 2
)
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       ext_reset_n,
	// Serial link
	input  wire logic       link_sck,
	input  wire logic       link_cs_n,
	input  wire logic       link_si,
	output logic            link_so_out,
	output logic            link_so_oe,
	// Hardware address straps
	input  wire logic       hw_addr_bit0,
	input  wire logic       hw_addr_bit1,
	input  wire logic       hw_addr_bit2,
	// Port pins
	input  wire logic [7:0] port_pin_in,
	output logic      [7:0] port_pin_out,
	output logic      [7:0] port_pin_oe,
	output logic      [7:0] port_pullup_on,
	// Interrupt pin
	output logic            int_out,
	output logic            int_oe
);

	// ************************************************************
	// Elaboration check
	// ************************************************************
	generate
		if (HW_ADDR_BITS != 2 && HW_ADDR_BITS != 3)
		begin : g_bad_param
			$error("HW_ADDR_BITS must be 2 or 3");
		end
	endgenerate

	logic [14:0]                    sync_bus;
	logic [7:0]                     pin_s;
	logic                           sck_s;
	logic                           cs_n_s;
	logic                           si_s;
	logic                           ext_reset_n_s;
	logic [2:0]                     hw_addr_s;
	logic                           rst;
	logic                           frame_start;
	logic                           rx_valid;
	logic [7:0]                     rx_byte;
	logic                           tx_enable;
	expander_pkg::frame_state_t     frame_q;
	logic                           read_q;
	logic [3:0]                     pointer_q;
	logic [7:0]                     tx_byte_q;
	logic [7:0]                     io_direction_q;
	logic [7:0]                     input_polarity_q;
	logic [7:0]                     change_int_enable_q;
	logic [7:0]                     default_compare_q;
	logic [7:0]                     int_cond_select_q;
	logic [7:0]                     device_config_q;
	logic [7:0]                     pullup_enable_q;
	logic [7:0]                     interrupt_flags_q;
	logic [7:0]                     interrupt_capture_q;
	logic [7:0]                     output_latch_q;
	logic [7:0]                     pin_prev_q;
	logic [7:0]                     port_value;
	logic [7:0]                     int_event;
	logic [7:0]                     read_mux;
	logic [6:0]                     ctrl_expected;
	logic                           wr_en;
	logic                           rd_done;
	logic                           int_clear;
	logic                           int_active;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	pin_sync #(
		.WIDTH    (15)
	) u_sync (
		.sys_clk  (sys_clk),
		.async_in ({hw_addr_bit2, hw_addr_bit1, hw_addr_bit0, ext_reset_n, link_si, link_cs_n, link_sck, port_pin_in}),
		.sync_out (sync_bus)
	);

	// Nothing touches a raw pin before the second stage
	assign pin_s         = sync_bus[7:0];
	assign sck_s         = sync_bus[8];
	assign cs_n_s        = sync_bus[9];
	assign si_s          = sync_bus[10];
	assign ext_reset_n_s = sync_bus[11];
	assign hw_addr_s     = sync_bus[14:12];

	// Power-on and pin reset act alike
	assign rst = srst | ~ext_reset_n_s;

	// ************************************************************
	// Serial shifter
	// ************************************************************
	spi_link u_link (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.sck_s       (sck_s),
		.cs_n_s      (cs_n_s),
		.si_s        (si_s),
		.tx_byte     (tx_byte_q),
		.tx_enable   (tx_enable),
		.frame_start (frame_start),
		.rx_valid    (rx_valid),
		.rx_byte     (rx_byte),
		.so_out      (link_so_out),
		.so_oe       (link_so_oe)
	);

	// ************************************************************
	// Control byte decode
	// ************************************************************
	// Unused address strap position is a fixed zero in the narrow variant
	assign ctrl_expected = (HW_ADDR_BITS == 3) ?
		{`CTRL_FIXED, hw_addr_s} :
		{`CTRL_FIXED, 1'b0, hw_addr_s[1:0]};

	assign tx_enable = read_q & (frame_q == expander_pkg::frame_data);
	assign wr_en     = rx_valid & ~read_q & (frame_q == expander_pkg::frame_data) & (pointer_q <= `ADDR_LAST);
	assign rd_done   = rx_valid & read_q & (frame_q == expander_pkg::frame_data);

	// Frame sequencing: opcode, address, then data bytes until deselect
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			frame_q <= expander_pkg::frame_opcode;
			read_q  <= 1'b0;
		end
		else if (frame_start)
		begin
			frame_q <= expander_pkg::frame_opcode;
			read_q  <= 1'b0;
		end
		else if (rx_valid)
		begin
			case (frame_q)
				expander_pkg::frame_opcode:
				begin
					read_q  <= rx_byte[`CTRL_RW_BIT];
					frame_q <= (rx_byte[7:1] == ctrl_expected) ? expander_pkg::frame_addr : expander_pkg::frame_skip;
				end
				expander_pkg::frame_addr:
					frame_q <= expander_pkg::frame_data;
				expander_pkg::frame_data:
					frame_q <= expander_pkg::frame_data;
				default:
					frame_q <= expander_pkg::frame_skip;
			endcase
		end
	end

	// ************************************************************
	// Address pointer
	// ************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			pointer_q <= `ADDR_IO_DIRECTION;
		else if (rx_valid && frame_q == expander_pkg::frame_addr)
			pointer_q <= rx_byte[3:0];
		else if (rx_valid && frame_q == expander_pkg::frame_data
			&& !device_config_q[`CFG_SEQ_DISABLE_BIT])
		begin
			// Out-of-range pointers also fold back to the first register
			if (pointer_q >= `ADDR_LAST)
				pointer_q <= `ADDR_IO_DIRECTION;
			else
				pointer_q <= pointer_q + 4'h1;
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			io_direction_q      <= `RST_IO_DIRECTION;
			input_polarity_q    <= `RST_ZERO;
			change_int_enable_q <= `RST_ZERO;
			default_compare_q   <= `RST_ZERO;
			int_cond_select_q   <= `RST_ZERO;
			device_config_q     <= `RST_ZERO;
			pullup_enable_q     <= `RST_ZERO;
			output_latch_q      <= `RST_ZERO;
		end
		else if (wr_en)
		begin
			case (pointer_q)
				`ADDR_IO_DIRECTION:      io_direction_q      <= rx_byte;
				`ADDR_INPUT_POLARITY:    input_polarity_q    <= rx_byte;
				`ADDR_CHANGE_INT_ENABLE: change_int_enable_q <= rx_byte;
				`ADDR_DEFAULT_COMPARE:   default_compare_q   <= rx_byte;
				`ADDR_INT_COND_SELECT:   int_cond_select_q   <= rx_byte;
				`ADDR_DEVICE_CONFIG:     device_config_q     <= rx_byte & `CFG_WRITE_MASK;
				`ADDR_PULLUP_ENABLE:     pullup_enable_q     <= rx_byte;
				// Port writes land in the latch
				`ADDR_PORT_VALUE:        output_latch_q      <= rx_byte;
				`ADDR_OUTPUT_LATCH:      output_latch_q      <= rx_byte;
				// Flags and capture ignore writes
				default:                 output_latch_q      <= output_latch_q;
			endcase
		end
	end

	// ************************************************************
	// Port value and interrupt conditions
	// ************************************************************
	assign port_value = pin_s ^ input_polarity_q;

	// Last sampled level, the reference of change mode
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			pin_prev_q <= 8'h00;
		else
			pin_prev_q <= pin_s;
	end

	// One condition per bit, picked by its select bit; only inputs take part
	generate
		for (genvar i = 0; i < 8; i++)
		begin : g_cond
			assign int_event[i] = change_int_enable_q[i] & io_direction_q[i] &
				(int_cond_select_q[i] ? (pin_s[i] != default_compare_q[i])
				                      : (pin_s[i] != pin_prev_q[i]));
		end
	endgenerate

	// Reading the port or capture register acknowledges the interrupt
	assign int_clear = rd_done & ((pointer_q == `ADDR_PORT_VALUE) || (pointer_q == `ADDR_INTERRUPT_CAPTURE));

	// Flags: a new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			interrupt_flags_q <= `RST_ZERO;
		else if (int_clear)
			interrupt_flags_q <= int_event;
		else
			interrupt_flags_q <= interrupt_flags_q | int_event;
	end

	// Capture only the first event so the cause is not overwritten
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			interrupt_capture_q <= `RST_ZERO;
		else if ((int_event != 8'h00) && ((interrupt_flags_q == 8'h00) || int_clear))
			interrupt_capture_q <= port_value;
	end

	// ************************************************************
	// Register read-back
	// ************************************************************
	always_comb
	begin
		case (pointer_q)
			`ADDR_IO_DIRECTION:      read_mux = io_direction_q;
			`ADDR_INPUT_POLARITY:    read_mux = input_polarity_q;
			`ADDR_CHANGE_INT_ENABLE: read_mux = change_int_enable_q;
			`ADDR_DEFAULT_COMPARE:   read_mux = default_compare_q;
			`ADDR_INT_COND_SELECT:   read_mux = int_cond_select_q;
			`ADDR_DEVICE_CONFIG:     read_mux = device_config_q;
			`ADDR_PULLUP_ENABLE:     read_mux = pullup_enable_q;
			`ADDR_INTERRUPT_FLAGS:   read_mux = interrupt_flags_q;
			`ADDR_INTERRUPT_CAPTURE: read_mux = interrupt_capture_q;
			`ADDR_PORT_VALUE:        read_mux = port_value;
			`ADDR_OUTPUT_LATCH:      read_mux = output_latch_q;
			default:                 read_mux = 8'h00;
		endcase
	end

	// Registered so the shifter sees a stable byte at its load edge
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			tx_byte_q <= 8'h00;
		else
			tx_byte_q <= read_mux;
	end

	// ************************************************************
	// Pin drivers
	// ************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			port_pin_out   <= 8'h00;
			port_pin_oe    <= 8'h00;
			port_pullup_on <= 8'h00;
		end
		else
		begin
			port_pin_out   <= output_latch_q;
			port_pin_oe    <= ~io_direction_q;
			port_pullup_on <= pullup_enable_q & io_direction_q;
		end
	end

	// ************************************************************
	// Interrupt pin
	// ************************************************************
	assign int_active = interrupt_flags_q != 8'h00;

	// Open drain pulls low only when active; push-pull always drives
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			// Inactive level of the default active-low push-pull mode
			int_out <= 1'b1;
			int_oe  <= 1'b1;
		end
		else if (device_config_q[`CFG_OPEN_DRAIN_BIT])
		begin
			int_out <= 1'b0;
			int_oe  <= int_active;
		end
		else
		begin
			int_out <= ~(int_active ^ device_config_q[`CFG_INT_POL_BIT]);
			int_oe  <= 1'b1;
		end
	end

endmodule : serial_io_expander_core

/* File: expander_props.sv */
// Checker of port-level behaviour for the I/O expander core
`timescale 1ns/10ps

module expander_props
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       ext_reset_n,
	// Link and pins
	input  wire logic       link_cs_n,
	input  wire logic       link_so_oe,
	input  wire logic [7:0] port_pin_out,
	input  wire logic [7:0] port_pin_oe,
	input  wire logic [7:0] port_pullup_on,
	input  wire logic       int_out,
	input  wire logic       int_oe
);
	// ************************************************************
	// Helper and properties
	// ************************************************************
	logic [3:0] ext_q;
	logic       ext_ok;

	// External reset window, held long enough to cover its synchroniser
	always_ff @(posedge sys_clk)
		ext_q <= {ext_q[2:0], ext_reset_n};
	assign ext_ok = (&ext_q) & ext_reset_n;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst || !ext_ok);

	property p_pull_input; (port_pullup_on & port_pin_oe) == 8'h00; endproperty
	a_pull_input: assert property (p_pull_input) else $error("pull-up on driven pin");
	property p_rst_dir; disable iff (!ext_ok) srst |=> (port_pin_oe == 8'h00); endproperty
	a_rst_dir: assert property (p_rst_dir) else $error("pins not inputs after reset");
	property p_rst_out; disable iff (!ext_ok) srst |=> (port_pin_out == 8'h00) && (port_pullup_on == 8'h00); endproperty
	a_rst_out: assert property (p_rst_out) else $error("latch or pull-ups not cleared");
	property p_rst_so; disable iff (!ext_ok) srst |=> !link_so_oe && int_oe && int_out; endproperty
	a_rst_so: assert property (p_rst_so) else $error("link or int pin wrong in reset");
	property p_idle_so; link_cs_n [*5] |-> !link_so_oe; endproperty
	a_idle_so: assert property (p_idle_so) else $error("data out driven while deselected");
	property p_od; !int_oe |-> !int_out; endproperty
	a_od: assert property (p_od) else $error("released int pin drives high");
	property p_out_quiet; link_cs_n [*8] |-> $stable(port_pin_out); endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("latch moved without access");
	property p_oe_quiet; link_cs_n [*8] |-> $stable(port_pin_oe); endproperty
	a_oe_quiet: assert property (p_oe_quiet) else $error("direction moved without access");

	c_read: cover property ($rose(link_so_oe));
	c_od: cover property ($fell(int_oe));
	c_out: cover property (port_pin_oe != 8'h00);
endmodule : expander_props

bind serial_io_expander_core expander_props u_props
(
	.sys_clk(sys_clk), .srst(srst), .ext_reset_n(ext_reset_n), .link_cs_n(link_cs_n),
	.link_so_oe(link_so_oe), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
	.port_pullup_on(port_pullup_on), .int_out(int_out), .int_oe(int_oe)
);

/* File: spi_host_model.sv */
// Host-side serial master model for the expander link
`timescale 1ns/10ps

module spi_host_model
(
	// Clock
	input  wire logic sys_clk,
	// Link pins
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	// ************************************************************
	// Link idle and transfer tasks
	// ************************************************************
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Half period of 40 ns is four system clocks
	task automatic half();
		repeat (4) @(posedge sys_clk);
	endtask : half

	// MSB first, answer sampled at each rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			si <= tx[i];
			half();
			sck <= 1'b1;
			rx[i] = so;
			half();
			sck <= 1'b0;
		end
	endtask : xfer

	// Chip select frames every transaction
	task automatic start(input logic [7:0] op, input logic [7:0] addr);
		logic [7:0] r;
		cs_n <= 1'b0;
		half();
		xfer(op, r);
		xfer(addr, r);
	endtask : start

	// Released data line flips so a stale level is never trusted
	task automatic stop();
		half();
		cs_n <= 1'b1;
		si <= ~si;
		repeat (8) @(posedge sys_clk);
	endtask : stop
endmodule : spi_host_model

/* File: tb.sv */
// Self-checking testbench of the I/O expander core
`timescale 1ns/10ps

module tb;
	// ************************************************************
	// Signals, instances and checking
	// ************************************************************
	logic       sys_clk;
	logic       srst;
	logic       ext_reset_n;
	logic       sck;
	logic       cs_n;
	logic       si;
	logic       so;
	logic       so_oe;
	logic       a0;
	logic       a1;
	logic [7:0] pins;
	logic [7:0] pout;
	logic [7:0] poe;
	logic [7:0] pull;
	logic       int_out;
	logic       int_oe;
	logic [7:0] opc;
	logic [7:0] d;
	int         fail_count;
	int         checks;
	logic [7:0] rst_tab [11] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00};

	// Released data line shows the inverse of its last level
	spi_host_model host (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so_oe ? so : ~so));

	serial_io_expander_core DUT
	(
		.sys_clk(sys_clk), .srst(srst), .ext_reset_n(ext_reset_n), .link_sck(sck), .link_cs_n(cs_n),
		.link_si(si), .link_so_out(so), .link_so_oe(so_oe), .hw_addr_bit0(a0), .hw_addr_bit1(a1),
		.hw_addr_bit2(1'b0), .port_pin_in(pins), .port_pin_out(pout), .port_pin_oe(poe),
		.port_pullup_on(pull), .int_out(int_out), .int_oe(int_oe)
	);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		logic [7:0] r;
		host.start(opc, {4'h0, a});
		host.xfer(v, r);
		host.stop();
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		host.start(opc | 8'h01, {4'h0, a});
		host.xfer(8'h00, v);
		host.stop();
	endtask : rd

	task automatic results();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// Clock of 10 ns
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Hang guard, far beyond the expected run
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		fail_count++;
		results();
	end

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial
	begin
		srst = 1'b1;
		ext_reset_n = 1'b1;
		a0 = 1'b0;
		a1 = 1'b0;
		pins = 8'h5a;
		opc = 8'h40;
		fail_count = 0;
		checks = 0;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		// Defaults over one sequential read that wraps
		host.start(8'h41, 8'h00);
		for (int i = 0; i < 12; i++)
		begin
			host.xfer(8'h00, d);
			chk(d, rst_tab[i % 11]);
		end
		host.stop();
		// Direction, pull-ups, latch and polarity
		wr(4'h0, 8'h0f);
		chk(poe, 8'hf0);
		wr(4'h6, 8'hff);
		chk(pull, 8'h0f);
		wr(4'h9, 8'h3c);
		chk(pout, 8'h3c);
		rd(4'ha, d);
		chk(d, 8'h3c);
		rd(4'h9, d);
		chk(d, 8'h5a);
		wr(4'h1, 8'hff);
		rd(4'h9, d);
		chk(d, 8'ha5);
		wr(4'h8, 8'h77);
		rd(4'h8, d);
		chk(d, 8'h00);
		// Beyond the last register reads as zero
		rd(4'hb, d);
		chk(d, 8'h00);
		// Fixed pointer repeats the same register
		wr(4'h5, 8'h20);
		host.start(8'h41, 8'h0a);
		host.xfer(8'h00, d);
		chk(d, 8'h3c);
		host.xfer(8'h00, d);
		chk(d, 8'h3c);
		host.stop();
		wr(4'h5, 8'h00);
		// Change mode on pin 0, active-low push-pull
		wr(4'h0, 8'hff);
		wr(4'h1, 8'h00);
		pins <= 8'h00;
		wr(4'h2, 8'h01);
		rd(4'h8, d);
		pins <= 8'h01;
		repeat (10) @(posedge sys_clk);
		chk({6'h00, int_oe, int_out}, 8'h02);
		rd(4'h7, d);
		chk(d, 8'h01);
		rd(4'h8, d);
		chk(d, 8'h01);
		chk({6'h00, int_oe, int_out}, 8'h03);
		// Compare mode holds while the pin differs
		wr(4'h4, 8'h01);
		chk({6'h00, int_oe, int_out}, 8'h02);
		wr(4'h5, 8'h02);
		chk({6'h00, int_oe, int_out}, 8'h03);
		wr(4'h5, 8'h04);
		chk({6'h00, int_oe, int_out}, 8'h02);
		pins <= 8'h00;
		rd(4'h8, d);
		rd(4'h7, d);
		chk(d, 8'h00);
		chk({6'h00, int_oe, int_out}, 8'h00);
		// Strap mismatch on both straps ignores the frame; setting both to match accepts it
		opc = 8'h46;
		wr(4'h0, 8'h00);
		chk(poe, 8'h00);
		a0 <= 1'b1;
		a1 <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wr(4'h0, 8'h00);
		chk(poe, 8'hff);
		// External reset pin
		ext_reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		ext_reset_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk(poe, 8'h00);
		rd(4'h0, d);
		chk(d, 8'hff);
		results();
	end
endmodule : tb
